//--- rtl/supply_regs.sv
// Purpose: power supply status and level register bank on AHB-Lite
// Assumes: one clock hclk; status flags and boot pins are asynchronous
// Notes: zero wait states; every response OKAY
//
// Behaviour
// - status bit 24 reads 1 while on-die oscillator is stable
// - status bit 19 pll supply good, bit 16 core supply good
// - status bit 9 analogue converter limiting, bit 8 core converter limiting
// - status bit 1 analogue converter soft-start, bit 0 core soft-start
// - core level register bits 6:0, 0.60 V plus 10 mV per step
// - both setpoint resets come from sampled boot configuration pins
// - pll regulator level bits 2:0, 0.6 V plus 100 mV per step
`timescale 1ns/1ps
module supply_regs
  import supply_regs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire supply_flags_s supply_flags,
  input wire logic [`CORE_CODE_W-1:0] boot_core_code,
  input wire logic [`PLL_CODE_W-1:0] boot_pll_code,
  output setpoints_s setpoints,
  output logic irq
);

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  localparam int SYNC_W = `EVT_W + `CORE_CODE_W + `PLL_CODE_W;

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  supply_flags_s flags;
  logic [`CORE_CODE_W-1:0] pin_core;
  logic [`PLL_CODE_W-1:0] pin_pll;

  assign sync_in = {supply_flags, boot_core_code, boot_pll_code};

  flag_sync #(
    .W(SYNC_W)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(sync_in),
    .sync_out(sync_out)
  );

  assign flags = supply_flags_s'(sync_out[SYNC_W-1 -: `EVT_W]);
  assign pin_core = sync_out[`PLL_CODE_W +: `CORE_CODE_W];
  assign pin_pll = sync_out[`PLL_CODE_W-1:0];

  // ----------------------------------------
  // status word assembly
  // ----------------------------------------
  function automatic logic [31:0] status_word(input supply_flags_s f);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`BIT_OSC_STABLE] = f.osc_stable;
    w[`BIT_PLL_GOOD] = f.pll_supply_good;
    w[`BIT_CORE_GOOD] = f.core_supply_good;
    w[`BIT_ANA_ILIM] = f.analogue_buck_ilim;
    w[`BIT_CORE_ILIM] = f.core_buck_ilim;
    w[`BIT_ANA_SOFT] = f.analogue_buck_soft;
    w[`BIT_CORE_SOFT] = f.core_buck_soft;
    return w;
  endfunction

  logic [31:0] status_now;
  assign status_now = status_word(flags);

  // ----------------------------------------
  // boot capture of setpoint defaults
  // ----------------------------------------
  boot_state_e boot_state;
  boot_state_e next_boot_state;
  logic boot_load;
  logic boot_armed;

  // wait until the pin synchroniser holds real levels: load on the third edge
  always_comb begin
    next_boot_state = boot_state;
    case (boot_state)
      boot_hold: next_boot_state = boot_armed ? boot_capture : boot_hold;
      boot_capture: next_boot_state = boot_done;
      boot_done: next_boot_state = boot_done;
      default: next_boot_state = boot_done;
    endcase
  end

  assign boot_load = (boot_state == boot_capture);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_state <= boot_hold;
      boot_armed <= 1'b0;
    end else begin
      boot_state <= next_boot_state;
      boot_armed <= 1'b1;
    end
  end

  // ----------------------------------------
  // ahb address phase capture
  // ----------------------------------------
  logic addr_valid;
  logic dp_active;
  logic dp_write;
  logic [7:0] dp_addr;

  assign addr_valid = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_active <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_active <= addr_valid;
      dp_write <= addr_valid && hwrite;
      dp_addr <= addr_valid ? haddr[7:0] : dp_addr;
    end
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic wr_core;
  logic wr_pll;
  logic wr_clear;
  logic wr_enable;
  logic rd_hit;

  assign wr_core = dp_write && (dp_addr == `OFS_CORE_SETPOINT);
  assign wr_pll = dp_write && (dp_addr == `OFS_PLL_SETPOINT);
  assign wr_clear = dp_write && (dp_addr == `OFS_EVT_CLEAR);
  assign wr_enable = dp_write && (dp_addr == `OFS_EVT_ENABLE);
  assign rd_hit = addr_valid && !hwrite;

  // ----------------------------------------
  // setpoint registers
  // ----------------------------------------
  logic [`CORE_CODE_W-1:0] core_code;
  logic [`PLL_CODE_W-1:0] pll_code;
  logic [`CORE_CODE_W-1:0] next_core_code;
  logic [`PLL_CODE_W-1:0] next_pll_code;

  // writes to status and reserved bits fall away here
  assign next_core_code = boot_load ? pin_core :
                          wr_core ? hwdata[`CORE_CODE_W-1:0] : core_code;
  assign next_pll_code = boot_load ? pin_pll :
                         wr_pll ? hwdata[`PLL_CODE_W-1:0] : pll_code;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_code <= '0;
      pll_code <= '0;
    end else begin
      core_code <= next_core_code;
      pll_code <= next_pll_code;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setpoints <= '0;
    end else begin
      setpoints.core_supply_code <= next_core_code;
      setpoints.pll_regulator_code <= next_pll_code;
    end
  end

  // ----------------------------------------
  // events: rising edges of status flags
  // ----------------------------------------
  logic [`EVT_W-1:0] flags_prev;
  logic [`EVT_W-1:0] evt_rise;
  logic [`EVT_W-1:0] evt_status;
  logic [`EVT_W-1:0] evt_enable;
  logic [`EVT_W-1:0] next_evt_status;
  logic [`EVT_W-1:0] clr_mask;

  assign evt_rise = flags & ~flags_prev;
  assign clr_mask = wr_clear ? hwdata[`EVT_W-1:0] : `EVT_RESET;
  // a new event in the clear cycle wins
  assign next_evt_status = (evt_status & ~clr_mask) | evt_rise;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_prev <= '1;
      evt_status <= `EVT_RESET;
      evt_enable <= `EVT_RESET;
      irq <= 1'b0;
    end else begin
      flags_prev <= flags;
      evt_status <= next_evt_status;
      evt_enable <= wr_enable ? hwdata[`EVT_W-1:0] : evt_enable;
      irq <= |(next_evt_status & (wr_enable ? hwdata[`EVT_W-1:0] : evt_enable));
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [31:0] rd_value;
  logic [7:0] rd_addr;

  assign rd_addr = haddr[7:0];

  always_comb begin
    if (rd_addr == `OFS_SUPPLY_STATUS) begin
      rd_value = status_now;
    end else if (rd_addr == `OFS_CORE_SETPOINT) begin
      rd_value = {25'h0, core_code};
    end else if (rd_addr == `OFS_PLL_SETPOINT) begin
      rd_value = {29'h0, pll_code};
    end else if (rd_addr == `OFS_EVT_STATUS) begin
      rd_value = {25'h0, evt_status};
    end else if (rd_addr == `OFS_EVT_ENABLE) begin
      rd_value = {25'h0, evt_enable};
    end else begin
      rd_value = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_hit) begin
      hrdata <= rd_value;
    end
  end

endmodule // supply_regs

//--- rtl/supply_regs_defines.svh
// Purpose: offsets, field positions and reset values for the supply register bank
// Assumes: 32-bit word registers on an AHB-Lite slave
// Notes: included by the package only; the register bank uses its macros through the package
`ifndef SUPPLY_REGS_DEFINES_SVH
`define SUPPLY_REGS_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_SUPPLY_STATUS 8'h30
`define OFS_CORE_SETPOINT 8'h34
`define OFS_PLL_SETPOINT 8'h40
`define OFS_EVT_STATUS 8'h50
`define OFS_EVT_CLEAR 8'h54
`define OFS_EVT_ENABLE 8'h58

// ----------------------------------------
// supply status fields
// ----------------------------------------
`define BIT_OSC_STABLE 24
`define BIT_PLL_GOOD 19
`define BIT_CORE_GOOD 16
`define BIT_ANA_ILIM 9
`define BIT_CORE_ILIM 8
`define BIT_ANA_SOFT 1
`define BIT_CORE_SOFT 0

// ----------------------------------------
// setpoint widths and event layout
// ----------------------------------------
`define CORE_CODE_W 7
`define PLL_CODE_W 3
`define EVT_W 7
`define EVT_RESET 7'h00

`endif

//--- rtl/supply_regs_pkg.sv
// Purpose: shared types for the supply register bank
// Assumes: defines header supplies field widths
// Notes: none
package supply_regs_pkg;
  `include "supply_regs_defines.svh"

  // ----------------------------------------
  // raw supply conditions from analogue side
  // ----------------------------------------
  typedef struct packed {
    logic osc_stable;
    logic pll_supply_good;
    logic core_supply_good;
    logic analogue_buck_ilim;
    logic core_buck_ilim;
    logic analogue_buck_soft;
    logic core_buck_soft;
  } supply_flags_s;

  // ----------------------------------------
  // requested supply levels
  // ----------------------------------------
  typedef struct packed {
    logic [`CORE_CODE_W-1:0] core_supply_code;
    logic [`PLL_CODE_W-1:0] pll_regulator_code;
  } setpoints_s;

  typedef enum logic [1:0] {
    boot_hold,
    boot_capture,
    boot_done
  } boot_state_e;
endpackage

//--- rtl/flag_sync.sv
// Purpose: two-stage synchroniser for a vector of asynchronous levels
// Assumes: inputs are slow levels from analogue monitors or pins
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module flag_sync #(
  parameter int W = 7
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  // ----------------------------------------
  // double flop
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // flag_sync

//--- tb/supply_regs_sva.sv
// Purpose: bus and setpoint checks for supply_regs
// Assumes: zero wait states, single word transfers
// Notes: bound to the top module
`timescale 1ns/1ps
module supply_regs_chk
  import supply_regs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire supply_flags_s supply_flags,
  input wire logic [6:0] boot_core_code,
  input wire logic [2:0] boot_pll_code,
  input wire setpoints_s setpoints,
  input wire logic irq
);
  wire ap = hsel && hready && htrans[1];
  wire rd = ap && !hwrite;
  wire wr = ap && hwrite;
  wire [7:0] a = haddr[7:0];
  wire [31:0] sw = {7'h0, supply_flags.osc_stable, 4'h0, supply_flags.pll_supply_good, 2'h0,
    supply_flags.core_supply_good, 6'h0, supply_flags.analogue_buck_ilim,
    supply_flags.core_buck_ilim, 6'h0, supply_flags.analogue_buck_soft,
    supply_flags.core_buck_soft};
  // ----
  // checks
  // ----
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("wait state or error response");
  status_read_a: assert property (rd && a == 8'h30 && $past(hresetn, 3) && $stable(supply_flags)
    && $past(supply_flags, 2) == supply_flags |=> hrdata == $past(sw)) else $error("status word");
  core_read_a: assert property (rd && a == 8'h34
    |=> hrdata == {25'h0, $past(setpoints.core_supply_code)}) else $error("core level read");
  pll_read_a: assert property (rd && a == 8'h40
    |=> hrdata == {29'h0, $past(setpoints.pll_regulator_code)}) else $error("pll level read");
  core_write_a: assert property (wr && a == 8'h34 && $past(hresetn, 3)
    |=> ##1 setpoints.core_supply_code == $past(hwdata[6:0])) else $error("core level write");
  pll_write_a: assert property (wr && a == 8'h40 && $past(hresetn, 3)
    |=> ##1 setpoints.pll_regulator_code == $past(hwdata[2:0])) else $error("pll level write");
  boot_load_a: assert property ($rose(hresetn)
    |-> ##3 setpoints == {boot_core_code, boot_pll_code}) else $error("boot levels");
  unmapped_zero_a: assert property (rd && !(a inside {8'h30, 8'h34, 8'h40, 8'h50, 8'h54, 8'h58})
    |=> hrdata == 32'h0) else $error("unmapped read");
  level_hold_a: assert property ($past(hresetn, 5) && !$past(wr && (a == 8'h34 || a == 8'h40), 2)
    |-> $stable(setpoints)) else $error("level changed");
  cover property (wr && a == 8'h34);
  cover property (rd && a == 8'h30);
  cover property ($rose(irq));
endmodule // supply_regs_chk

bind supply_regs supply_regs_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .supply_flags(supply_flags),
  .boot_core_code(boot_core_code), .boot_pll_code(boot_pll_code), .setpoints(setpoints),
  .irq(irq));

//--- tb/tb_supply_regs.sv
// Purpose: self-checking bench for supply_regs
// Assumes: zero wait state slave, boot codes fixed
// Notes: one task per scenario
`timescale 1ns/1ps
module tb_supply_regs
  import supply_regs_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  supply_flags_s supply_flags;
  setpoints_s setpoints;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  supply_regs i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .supply_flags(supply_flags),
    .boot_core_code(7'h46), .boot_pll_code(3'h6), .setpoints(setpoints), .irq(irq)
  );
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // ----
  // helpers
  // ----
  task automatic print_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    bus(1'b0, a, 32'h0);
    check(q, exp, msg);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_levels();
    rd_chk(8'h34, 32'h46, "core boot level");
    rd_chk(8'h40, 32'h6, "pll boot level");
    bus(1'b1, 8'h34, 32'hffff_ffc7);
    bus(1'b1, 8'h40, 32'hffff_fff9);
    rd_chk(8'h34, 32'h47, "core level");
    rd_chk(8'h40, 32'h1, "pll level");
    check({22'h0, setpoints}, {22'h0, 7'h47, 3'h1}, "level outputs");
    bus(1'b1, 8'h3c, 32'hffff_ffff);
    rd_chk(8'h3c, 32'h0, "unmapped");
    $display("levels done");
  endtask
  task automatic t_status();
    logic [6:0] pat [3] = '{7'h7f, 7'h55, 7'h2a};
    logic [31:0] exp [3] = '{32'h0109_0303, 32'h0101_0101, 32'h0008_0202};
    for (int i = 0; i < 3; i++) begin
      supply_flags <= pat[i];
      repeat (3) @(posedge hclk);
      bus(1'b1, 8'h30, 32'hffff_ffff);
      rd_chk(8'h30, exp[i], "status word");
    end
    $display("status done");
  endtask
  task automatic t_irq();
    supply_flags <= 7'h00;
    repeat (4) @(posedge hclk);
    bus(1'b1, 8'h54, 32'h7f);
    bus(1'b1, 8'h58, 32'h1);
    supply_flags <= 7'h01;
    repeat (6) @(posedge hclk);
    check({31'h0, irq}, 32'h1, "irq raised");
    rd_chk(8'h50, 32'h1, "event status");
    bus(1'b1, 8'h58, 32'h0);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0, "irq masked");
    bus(1'b1, 8'h58, 32'h1);
    bus(1'b1, 8'h54, 32'h1);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    $display("irq done");
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwdata = 32'h0;
    supply_flags = 7'h00;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    t_levels();
    t_status();
    t_irq();
    print_verdict();
  end
endmodule // tb_supply_regs
